// ==== logic/apcc_regs.vh ====
// Constants for the converter power, reference and channel control block.
`ifndef APCC_REGS_VH
`define APCC_REGS_VH
`define APCC_CTRL_WIDTH 8
`define APCC_CTRL_RESET 8'h00
`define APCC_POWER_MODE_LO_BIT 0
`define APCC_POWER_MODE_HI_BIT 1
`define APCC_INPUT_SEL_BIT 3
`define APCC_CHANNEL_COUNT_SEL_BIT 4
`define APCC_REF_BIT_POSITION 5
`define APCC_RESULT_WIDTH 12
`define APCC_FRAME_BITS 16
`define APCC_PM_SELECT_CONTROLLED_POWERDOWN 2'h0
`define APCC_PM_ALWAYS_ON 2'h1
`define APCC_PM_AUTO_SHUTDOWN 2'h2
`define APCC_PM_AUTO_STANDBY 2'h3
`define APCC_REF_INTERNAL 2'h0
`define APCC_REF_EXTERNAL 2'h1
`define APCC_REF_SUPPLY 2'h2
`endif

// ==== logic/apcc_control.v ====
// Serial control port, power management and reference/channel selection.
// Operation
// - Mode 00: powered while select low, down while select high.
// - Mode 01: always fully powered regardless of logic inputs.
// - Mode 10: power down after every conversion, independent of select.
// - Mode 11: standby after conversion, internal reference stays powered.
// - Reference bit 0 uses internal reference; 1 disables it for external.
// - Channel-count bit 1: two channels, supply voltage is reference.
// - Channel-count 0, reference 0: second pin is reference, internal used.
// - Input-select bit routes first input at 0, second input at 1.
// - Support 125 ksps with a 2 MHz serial clock.
// - Each conversion yields a 12-bit result shifted out serially.
`include "apcc_regs.vh"
module apcc_control #(
	parameter CTRL_WIDTH = `APCC_CTRL_WIDTH,
	parameter RESULT_WIDTH = `APCC_RESULT_WIDTH,
	parameter FRAME_BITS = `APCC_FRAME_BITS
) (
	// Clock and reset.
	input wire clk,
	input wire rst,
	// Serial pins from the host.
	input wire cs_n,
	input wire sclk,
	input wire din,
	output reg dout,
	output wire dout_oe,
	// Converter core handshake.
	output reg conv_start,
	input wire conv_done,
	input wire [RESULT_WIDTH-1:0] conv_result,
	// Analog control outputs.
	output reg core_power_on,
	output reg ref_power_on,
	output reg [1:0] ref_source,
	output reg input_route_second,
	output reg dual_channel,
	output reg [1:0] power_mode
);

	reg cs_m;
	reg cs_s;
	reg cs_d;
	reg sclk_m;
	reg sclk_s;
	reg sclk_d;
	reg din_m;
	reg din_s;
	reg [CTRL_WIDTH-1:0] ctrl;
	reg [CTRL_WIDTH-1:0] ctrl_shift;
	reg [4:0] bit_count;
	reg [FRAME_BITS-1:0] out_shift;
	reg [RESULT_WIDTH-1:0] result;
	reg next_core_power_on;
	wire cs_fall;
	wire sclk_rise;
	wire sclk_fall;
	wire [1:0] mode;
	wire ref_disable;
	wire int_ref_used;

	// One-clock edge pulse from the delayed and the current synced level.
	function apcc_edge;
		input prev_level;
		input cur_level;
		input want_rise;
		begin
			if (want_rise) begin
				apcc_edge = ~prev_level & cur_level;
			end else begin
				apcc_edge = prev_level & ~cur_level;
			end
		end
	endfunction

	// Bit counter step; it sticks at its top so long frames cannot wrap.
	function [4:0] apcc_count_step;
		input [4:0] count;
		begin
			if (count == 5'h1f) begin
				apcc_count_step = count;
			end else begin
				apcc_count_step = count + 5'h01;
			end
		end
	endfunction

	// Two-channel mode always converts against the supply.
	function [1:0] apcc_ref_pick;
		input two_channel;
		input ref_off;
		begin
			if (two_channel) begin
				apcc_ref_pick = `APCC_REF_SUPPLY;
			end else if (ref_off) begin
				apcc_ref_pick = `APCC_REF_EXTERNAL;
			end else begin
				apcc_ref_pick = `APCC_REF_INTERNAL;
			end
		end
	endfunction

	assign cs_fall = apcc_edge(cs_d, cs_s, 1'b0);
	assign sclk_rise = apcc_edge(sclk_d, sclk_s, 1'b1);
	assign sclk_fall = apcc_edge(sclk_d, sclk_s, 1'b0);
	assign mode = {ctrl[`APCC_POWER_MODE_HI_BIT],
		ctrl[`APCC_POWER_MODE_LO_BIT]};
	assign ref_disable = ctrl[`APCC_REF_BIT_POSITION];
	// The internal reference is only needed in single-channel, ref bit 0.
	assign int_ref_used = ~ctrl[`APCC_CHANNEL_COUNT_SEL_BIT] & ~ref_disable;
	// The data pin is driven only while the synced select is low.
	assign dout_oe = ~cs_s;

	always @(posedge clk) begin
		if (rst) begin
			cs_m <= 1'b1;
			cs_s <= 1'b1;
			cs_d <= 1'b1;
			// Serial clock idles high, so no false edge follows reset.
			sclk_m <= 1'b1;
			sclk_s <= 1'b1;
			sclk_d <= 1'b1;
			din_m <= 1'b0;
			din_s <= 1'b0;
		end else begin
			cs_m <= cs_n;
			cs_s <= cs_m;
			cs_d <= cs_s;
			sclk_m <= sclk;
			sclk_s <= sclk_m;
			sclk_d <= sclk_s;
			din_m <= din;
			din_s <= din_m;
		end
	end

	// Serial frame: control word in on rising, result out on falling.
	always @(posedge clk) begin
		if (rst) begin
			ctrl <= `APCC_CTRL_RESET;
			ctrl_shift <= {CTRL_WIDTH{1'b0}};
			bit_count <= 5'h00;
			out_shift <= {FRAME_BITS{1'b0}};
			dout <= 1'b0;
			conv_start <= 1'b0;
			result <= {RESULT_WIDTH{1'b0}};
		end else begin
			conv_start <= cs_fall;
			if (conv_done) begin
				result <= conv_result;
			end
			if (cs_fall) begin
				bit_count <= 5'h00;
				// Leading zeros, then the previous result MSB first.
				out_shift <= {{(FRAME_BITS-RESULT_WIDTH){1'b0}}, result
					} << 1;
				dout <= 1'b0;
			end else if (~cs_s) begin
				if (sclk_rise && bit_count < CTRL_WIDTH) begin
					ctrl_shift <= {ctrl_shift[CTRL_WIDTH-2:0], din_s};
					bit_count <= apcc_count_step(bit_count);
					if (bit_count == CTRL_WIDTH - 1) begin
						ctrl <= {ctrl_shift[CTRL_WIDTH-2:0], din_s};
					end
				end else if (sclk_rise) begin
					bit_count <= apcc_count_step(bit_count);
				end
				if (sclk_fall) begin
					dout <= out_shift[FRAME_BITS-1];
					out_shift <= {out_shift[FRAME_BITS-2:0], 1'b0};
				end
			end
		end
	end

	always @* begin
		next_core_power_on = core_power_on;
		case (mode)
			`APCC_PM_SELECT_CONTROLLED_POWERDOWN: begin
				next_core_power_on = ~cs_s;
			end
			`APCC_PM_ALWAYS_ON: begin
				next_core_power_on = 1'b1;
			end
			`APCC_PM_AUTO_SHUTDOWN, `APCC_PM_AUTO_STANDBY: begin
				if (cs_fall) begin
					next_core_power_on = 1'b1;
				end else if (conv_done) begin
					next_core_power_on = 1'b0;
				end
			end
			default: begin
				next_core_power_on = 1'b1;
			end
		endcase
	end

	always @(posedge clk) begin
		if (rst) begin
			core_power_on <= 1'b0;
			ref_power_on <= 1'b0;
			ref_source <= `APCC_REF_INTERNAL;
			input_route_second <= 1'b0;
			dual_channel <= 1'b0;
			power_mode <= `APCC_PM_SELECT_CONTROLLED_POWERDOWN;
		end else begin
			core_power_on <= next_core_power_on;
			// Standby keeps the internal reference alive for fast wake.
			ref_power_on <= int_ref_used & (next_core_power_on |
				(mode == `APCC_PM_AUTO_STANDBY));
			ref_source <= apcc_ref_pick(ctrl[`APCC_CHANNEL_COUNT_SEL_BIT],
				ref_disable);
			input_route_second <= ctrl[`APCC_INPUT_SEL_BIT];
			dual_channel <= ctrl[`APCC_CHANNEL_COUNT_SEL_BIT];
			power_mode <= mode;
		end
	end

endmodule

// ==== bench/apcc_control_assertions.sv ====
// Concurrent checks on the control block ports.
module apcc_control_assertions (
	// Clock and reset.
	input wire clk,
	input wire rst,
	// Serial select and data enable.
	input wire cs_n,
	input wire dout_oe,
	// Converter handshake.
	input wire conv_start,
	input wire conv_done,
	// Power, reference and channel state.
	input wire core_power_on,
	input wire ref_power_on,
	input wire dual_channel,
	input wire [1:0] ref_source,
	input wire [1:0] power_mode
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	sequence sel_off_s; (cs_n && power_mode == 2'h0) [*5]; endsequence
	sequence sel_on_s; (!cs_n && power_mode == 2'h0) [*5]; endsequence
	start_pulse_a:
	assert property (conv_start |=> !conv_start) else $error("long start");
	start_after_a:
	assert property ($fell(cs_n) |-> ##[2:5] conv_start) else $error("no start");
	oe_idle_a:
	assert property (cs_n [*4] |-> !dout_oe) else $error("oe stuck");
	oe_frame_a:
	assert property (conv_start |-> dout_oe) else $error("oe missing");
	sel_down_a:
	assert property (sel_off_s |-> !core_power_on) else $error("not down");
	sel_up_a:
	assert property (sel_on_s |-> core_power_on) else $error("not up");
	always_on_a:
	assert property ((power_mode == 2'h1) [*3] |-> core_power_on)
		else $error("mode 01 down");
	auto_down_a:
	assert property (conv_done && power_mode[1] |=> !core_power_on)
		else $error("no auto down");
	standby_ref_a:
	assert property ((power_mode == 2'h3 && ref_source == 2'h0 &&
		!dual_channel) [*3] |-> ref_power_on) else $error("ref off");
	supply_ref_a:
	assert property (dual_channel [*3] |-> ref_source == 2'h2)
		else $error("not supply");
endmodule
bind apcc_control apcc_control_assertions i_apcc_control_assertions (
	.clk(clk),
	.rst(rst),
	.cs_n(cs_n),
	.dout_oe(dout_oe),
	.conv_start(conv_start),
	.conv_done(conv_done),
	.core_power_on(core_power_on),
	.ref_power_on(ref_power_on),
	.dual_channel(dual_channel),
	.ref_source(ref_source),
	.power_mode(power_mode)
);

// ==== bench/apcc_host_model.sv ====
// Host model that frames a control word and collects the result.
module apcc_host_model (
	// Serial pins driven towards the block.
	output logic cs_n,
	output logic sclk,
	output logic din,
	// Data pin and its enable from the block.
	input wire logic dout,
	input wire logic dout_oe
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [15:0] rx;
	initial begin
		cs_n = 1;
		sclk = 1;
		din = 0;
	end
	// A released data pin reads as the inverse, so a late enable shows.
	task automatic send(input logic [7:0] w);
		cs_n = 0;
		for (int i = 15; i >= 0; i--) begin
			#160 sclk = 0;
			din = (i > 7) ? w[i-8] : ~din;
			#160 sclk = 1;
			rx[i] = dout_oe ? dout : ~dout;
		end
		#160 cs_n = 1;
		din = ~din;
	endtask
endmodule

// ==== bench/apcc_control_tb_top.sv ====
// Testbench for the power, reference and channel control block.
module apcc_control_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin \
	n_mismatch++; $display("CHECK FAILED %0t got %h exp %h", $time, a, b); \
	end end
	logic clk = 0, rst = 1, conv_done = 0;
	logic [11:0] conv_result = 12'h0000, last_res = 12'h0000;
	wire cs_n, sclk, din, dout, dout_oe, conv_start, core_power_on;
	wire ref_power_on, input_route_second, dual_channel;
	wire [1:0] ref_source, power_mode;
	int n_mismatch = 0, tests_run = 0;
	always #20 clk = ~clk;
	always @(negedge clk) conv_done <= conv_start;
	apcc_control i_apcc_control (
		.clk(clk),
		.rst(rst),
		.cs_n(cs_n),
		.sclk(sclk),
		.din(din),
		.dout(dout),
		.dout_oe(dout_oe),
		.conv_start(conv_start),
		.conv_done(conv_done),
		.conv_result(conv_result),
		.core_power_on(core_power_on),
		.ref_power_on(ref_power_on),
		.ref_source(ref_source),
		.input_route_second(input_route_second),
		.dual_channel(dual_channel),
		.power_mode(power_mode)
	);
	apcc_host_model i_apcc_host_model (
		.cs_n(cs_n),
		.sclk(sclk),
		.din(din),
		.dout(dout),
		.dout_oe(dout_oe)
	);
	// Frame spacing keeps the reduced sample rate and the wake-up time.
	localparam int GAP_CYCLES = 180;
	task automatic frame(input logic [7:0] w);
		i_apcc_host_model.send(w);
		repeat (8) @(negedge clk);
		`CHK(i_apcc_host_model.rx, {3'h0, last_res, 1'b0})
		`CHK(dout_oe, 1'b0)
		last_res = conv_result;
		conv_result = conv_result + 12'h05a3;
		repeat (GAP_CYCLES) @(negedge clk);
	endtask
	task automatic t_modes;
		for (int m = 0; m < 4; m++) begin
			frame({6'h00, m[1:0]});
			frame({6'h00, m[1:0]});
			`CHK(power_mode, m[1:0])
			`CHK(core_power_on, m == 1)
			`CHK(ref_power_on, m[0])
		end
	endtask
	task automatic t_ref;
		for (int k = 0; k < 4; k++) begin
			frame({2'b00, k[0], k[1], ^k[1:0], 3'b001});
			`CHK(ref_source, k[1] ? 2'h2 : {1'b0, k[0]})
			`CHK(ref_power_on, k == 0)
			`CHK(dual_channel, k[1])
			`CHK(input_route_second, ^k[1:0])
		end
	endtask
	task automatic summarize;
		$display("mismatches %0d of %0d checks", n_mismatch, tests_run);
		if (n_mismatch == 0 && tests_run > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial begin
		repeat (12) @(negedge clk);
		rst = 0;
		repeat (4) @(negedge clk);
		t_modes();
		t_ref();
		summarize();
	end
endmodule
